// [hdl/cia_defs.svh]
`ifndef CIA_DEFS_SVH
`define CIA_DEFS_SVH
// apb register offsets
`define CIA_OFF_CTRL 12'h000
`define CIA_OFF_INSTR 12'h004
`define CIA_OFF_FILE 12'h008
`define CIA_OFF_WORKING_ACCUMULATOR 12'h00C
`define CIA_OFF_STATUS 12'h010
`define CIA_OFF_PC 12'h014
`define CIA_OFF_RESULT 12'h018
// ctrl fields
`define CIA_CTRL_GO 0
`define CIA_CTRL_CARRYIN 1
`define CIA_CTRL_COND 2
`define CIA_CTRL_INTMEM 3
`define CIA_CTRL_IRQ 4
`define CIA_CTRL_PROGRAM_COUNTER_UPPER_LATCH_LSB 8
// status fields
`define CIA_ST_C 0
`define CIA_ST_DC 1
`define CIA_ST_Z 2
`define CIA_ST_OV 3
`define CIA_ST_BUSY 4
`define CIA_ST_WWR 5
`define CIA_ST_FWR 6
`define CIA_ST_SKIPNOP 7
// reset values
`define CIA_RST_WORD 32'h0000_0000
// working accumulator's own file address
`define CIA_WORKING_ACCUMULATOR_ADDR 8'h0A
// program counter low byte file address
`define CIA_PCL_ADDR 8'h02
// extra busy cycles after the first one of an instruction
`define CIA_EXTRA_NONE 2'd0
`define CIA_EXTRA_ONE 2'd1
`define CIA_EXTRA_TWO 2'd2
`endif

// [hdl/cia_pkg.sv]
package cia_pkg;
    typedef enum logic [3:0] {
        CIA_OP_IDLE, CIA_OP_ADD_LITERAL_OP, CIA_OP_ADD_TO_FILE_OP, CIA_OP_ADD_WITH_CARRY_OP, CIA_OP_SFILE,
        CIA_OP_LONG_SUBROUTINE_CALL, CIA_OP_TRD, CIA_OP_TWT, CIA_OP_SKIP, CIA_OP_BRANCH, CIA_OP_OTHER
    } cia_op_t;
endpackage : cia_pkg

// [hdl/cia_core.sv]
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "cia_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cia_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PROG} cia_st_t;

    // software-visible registers, then sequencer and bus-answer state
    logic [31:0] ctrl, next_ctrl;
    logic [15:0] instr, next_instr;
    logic [7:0] fileVal, next_fileVal;
    logic [7:0] working_accumulator, next_working_accumulator;
    logic [7:0] flags, next_flags;
    logic [15:0] pc, next_pc;
    logic [7:0] result, next_result;
    logic [1:0] cyclesLeft, next_cyclesLeft;
    cia_st_t state, next_state;
    logic [31:0] prdata_n;
    logic pready_n;
    logic pslverr_n;
    logic access;
    // decode and adder nets
    cia_pkg::cia_op_t op;
    logic [8:0] sum;
    logic [4:0] nib;
    logic ovf;
    logic carryIn;
    logic dBit;
    logic [7:0] addA, addB;

    // the access phase of an apb transfer
    assign access = psel && penable;

    // opcode classification
    // the all-zero word is checked first so it never decodes as an add
    always_comb begin
        op = cia_pkg::CIA_OP_OTHER;
        if (instr == 16'h0000) begin
            op = cia_pkg::CIA_OP_IDLE;
        end else if (instr[15:8] == 8'hB1) begin
            op = cia_pkg::CIA_OP_ADD_LITERAL_OP;
        end else if (instr[15:9] == 7'b0000_111) begin
            op = cia_pkg::CIA_OP_ADD_TO_FILE_OP;
        end else if (instr[15:9] == 7'b0001_000) begin
            op = cia_pkg::CIA_OP_ADD_WITH_CARRY_OP;
        end else if (instr[15:8] == 8'hB7) begin
            op = cia_pkg::CIA_OP_LONG_SUBROUTINE_CALL;
        end else if (instr[15:10] == 6'b1010_10) begin
            op = cia_pkg::CIA_OP_TRD;
        end else if (instr[15:10] == 6'b1010_11) begin
            op = cia_pkg::CIA_OP_TWT;
        end else if (instr[15:13] == 3'b110 || instr[15:13] == 3'b111) begin
            op = cia_pkg::CIA_OP_BRANCH;
        end else if (instr[15:9] == 7'b0001_011 || instr[15:9] == 7'b0010_011
                || instr[15:9] == 7'b0001_111 || instr[15:9] == 7'b0010_010
                || instr[15:8] == 8'h33 || instr[15:12] == 4'h9) begin
            op = cia_pkg::CIA_OP_SKIP;
        end else if (instr[15:9] == 7'b0010_110 || instr[15:9] == 7'b0010_101) begin
            op = cia_pkg::CIA_OP_SFILE;
        end
    end

    // shared adder with flag generation
    always_comb begin
        dBit = instr[8];
        // only the carry variant folds the stored carry into the sum
        if (op == cia_pkg::CIA_OP_ADD_WITH_CARRY_OP) begin
            carryIn = flags[`CIA_ST_C];
        end else begin
            carryIn = 1'b0;
        end
        addA = working_accumulator;
        // the literal form takes its operand from the opcode's low byte
        if (op == cia_pkg::CIA_OP_ADD_LITERAL_OP) begin
            addB = instr[7:0];
        end else begin
            addB = fileVal;
        end
        // one adder serves all three forms, so their flags agree
        sum = {1'b0, addA} + {1'b0, addB} + {8'h00, carryIn};
        // digit carry comes from a separate low-nibble sum
        nib = {1'b0, addA[3:0]} + {1'b0, addB[3:0]} + {4'h0, carryIn};
        // overflow: like-signed operands giving a result of the other sign
        ovf = (addA[7] == addB[7]) && (sum[7] != addA[7]);
    end

    // execution sequencer and register writes
    always_comb begin
        next_ctrl = ctrl;
        next_instr = instr;
        next_fileVal = fileVal;
        next_working_accumulator = working_accumulator;
        next_flags = flags;
        next_pc = pc;
        next_result = result;
        next_cyclesLeft = cyclesLeft;
        next_state = state;
        // go is a one-cycle strobe: it clears itself unless written again
        next_ctrl[`CIA_CTRL_GO] = 1'b0;
        // a write lands only at the edge where the master sees pready high,
        // so a held access phase never applies the same word twice
        if (access && pwrite && pready) begin
            case (paddr)
                `CIA_OFF_CTRL: next_ctrl = pwdata;
                `CIA_OFF_INSTR: next_instr = pwdata[15:0];
                `CIA_OFF_FILE: next_fileVal = pwdata[7:0];
                `CIA_OFF_WORKING_ACCUMULATOR: next_working_accumulator = pwdata[7:0];
                `CIA_OFF_STATUS: next_flags[3:0] = pwdata[3:0];
                `CIA_OFF_PC: next_pc = pwdata[15:0];
                default: begin
                end
            endcase
        end
        // the sequencer; busy marks an instruction in flight
        case (state)
            ST_IDLE: begin
                if (ctrl[`CIA_CTRL_GO]) begin
                    next_flags[7:4] = 4'h0;
                    next_flags[`CIA_ST_BUSY] = 1'b1;
                    next_state = ST_EXEC;
                    next_cyclesLeft = `CIA_EXTRA_NONE;
                    case (op)
                        // the literal add always lands in the accumulator
                        cia_pkg::CIA_OP_ADD_LITERAL_OP: begin
                            next_working_accumulator = sum[7:0];
                            next_result = sum[7:0];
                            next_flags[`CIA_ST_WWR] = 1'b1;
                        end
                        // d picks the destination of the sum
                        cia_pkg::CIA_OP_ADD_TO_FILE_OP, cia_pkg::CIA_OP_ADD_WITH_CARRY_OP: begin
                            next_result = sum[7:0];
                            if (!dBit) begin
                                next_working_accumulator = sum[7:0];
                                next_flags[`CIA_ST_WWR] = 1'b1;
                            end else begin
                                next_fileVal = sum[7:0];
                                next_flags[`CIA_ST_FWR] = 1'b1;
                            end
                        end
                        // set/negate class: the write targets are reported and result takes the file value
                        cia_pkg::CIA_OP_SFILE: begin
                            next_result = fileVal;
                            if (instr[7:0] == `CIA_WORKING_ACCUMULATOR_ADDR) begin
                                next_flags[`CIA_ST_WWR] = 1'b1;
                            end else begin
                                next_flags[`CIA_ST_FWR] = 1'b1;
                                next_flags[`CIA_ST_WWR] = !dBit;
                            end
                        end
                        // long call: upper byte from the latch field, low byte from the literal
                        cia_pkg::CIA_OP_LONG_SUBROUTINE_CALL: begin
                            next_pc = {ctrl[`CIA_CTRL_PROGRAM_COUNTER_UPPER_LATCH_LSB +: 8], instr[7:0]};
                            next_cyclesLeft = `CIA_EXTRA_ONE;
                        end
                        // branches refill the fetch slot, so they cost one more cycle
                        cia_pkg::CIA_OP_BRANCH: begin
                            next_cyclesLeft = `CIA_EXTRA_ONE;
                        end
                        // a table read into the program counter low byte takes two extra cycles, any other one
                        cia_pkg::CIA_OP_TRD: begin
                            if (instr[7:0] == `CIA_PCL_ADDR) begin
                                next_cyclesLeft = `CIA_EXTRA_TWO;
                            end else begin
                                next_cyclesLeft = `CIA_EXTRA_ONE;
                            end
                        end
                        // internal programming has no fixed length; it waits for the event
                        cia_pkg::CIA_OP_TWT: begin
                            if (ctrl[`CIA_CTRL_INTMEM]) begin
                                next_state = ST_PROG;
                            end else begin
                                next_cyclesLeft = `CIA_EXTRA_ONE;
                            end
                        end
                        // a true condition turns the prefetched word into an idle operation
                        cia_pkg::CIA_OP_SKIP: begin
                            if (ctrl[`CIA_CTRL_COND]) begin
                                next_cyclesLeft = `CIA_EXTRA_ONE;
                                next_flags[`CIA_ST_SKIPNOP] = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                    // only the add forms touch the arithmetic flags; all else keeps them
                    if (op == cia_pkg::CIA_OP_ADD_LITERAL_OP || op == cia_pkg::CIA_OP_ADD_TO_FILE_OP
                            || op == cia_pkg::CIA_OP_ADD_WITH_CARRY_OP) begin
                        next_flags[`CIA_ST_C] = sum[8];
                        next_flags[`CIA_ST_DC] = nib[4];
                        next_flags[`CIA_ST_Z] = (sum[7:0] == 8'h00);
                        next_flags[`CIA_ST_OV] = ovf;
                    end
                end
            end
            // count down the extra cycles, then drop busy
            ST_EXEC: begin
                if (cyclesLeft == 2'd0) begin
                    next_state = ST_IDLE;
                    next_flags[`CIA_ST_BUSY] = 1'b0;
                end else begin
                    next_cyclesLeft = cyclesLeft - 2'd1;
                end
            end
            // programming only ends on the event bit; software must set it
            ST_PROG: begin
                if (ctrl[`CIA_CTRL_IRQ]) begin
                    next_state = ST_IDLE;
                    next_flags[`CIA_ST_BUSY] = 1'b0;
                end
            end
            // an illegal state code falls back to idle
            default: next_state = ST_IDLE;
        endcase
    end

    // apb read mux
    // pready rises one cycle after the access phase starts and lasts one cycle;
    // an unmapped word is answered with pslverr and changes nothing
    always_comb begin
        pready_n = access && !pready;
        pslverr_n = 1'b0;
        prdata_n = `CIA_RST_WORD;
        if (access && !pready) begin
            case (paddr)
                `CIA_OFF_CTRL: prdata_n = ctrl;
                `CIA_OFF_INSTR: prdata_n = {16'h0000, instr};
                `CIA_OFF_FILE: prdata_n = {24'h00_0000, fileVal};
                `CIA_OFF_WORKING_ACCUMULATOR: prdata_n = {24'h00_0000, working_accumulator};
                `CIA_OFF_STATUS: prdata_n = {24'h00_0000, flags};
                `CIA_OFF_PC: prdata_n = {16'h0000, pc};
                `CIA_OFF_RESULT: prdata_n = {24'h00_0000, result};
                default: pslverr_n = 1'b1;
            endcase
        end
    end

    // bus answer registers
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= `CIA_RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_n;
            pready <= pready_n;
            pslverr <= pslverr_n;
        end
    end

    // execution state registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= `CIA_RST_WORD;
            instr <= 16'h0000;
            fileVal <= 8'h00;
            working_accumulator <= 8'h00;
            flags <= 8'h00;
            pc <= 16'h0000;
            result <= 8'h00;
            cyclesLeft <= 2'd0;
            state <= ST_IDLE;
        end else begin
            ctrl <= next_ctrl;
            instr <= next_instr;
            fileVal <= next_fileVal;
            working_accumulator <= next_working_accumulator;
            flags <= next_flags;
            pc <= next_pc;
            result <= next_result;
            cyclesLeft <= next_cyclesLeft;
            state <= next_state;
        end
    end
endmodule : cia_core
`default_nettype wire

// [sim/cia_core_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cia_core_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // answer timing and framing of each transfer
    a_ready_after_access: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
    // address decode
    a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (pready && paddr < 12'h01C |-> !pslverr)
        else $error("mapped refused");
    // narrow registers read zero above their width
    a_status_narrow: assert property (pready && !pwrite && paddr == 12'h010
        |-> prdata[31:8] == 24'h0) else $error("status upper bits set");
    a_pc_narrow: assert property (pready && !pwrite && paddr == 12'h014
        |-> prdata[31:16] == 16'h0) else $error("pc upper bits set");
    // main traffic
    cover property (pready && pwrite);
    cover property (pready && !pwrite && paddr == 12'h010);
    cover property (pslverr);
endmodule : cia_core_monitor
bind cia_core cia_core_monitor u_cia_core_monitor (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [sim/cia_add_ref.sv]
`timescale 1ns/1ps
`default_nettype none
module cia_add_ref (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] res,
    output logic [3:0] flags
);
    logic [8:0] sum;
    logic [4:0] low;
    // accumulator plus operand plus carry; flags are {ov, z, dc, c}
    assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign res = sum[7:0];
    assign flags = {(a[7] == b[7]) && (res[7] != a[7]), res == 8'h00, low[4], sum[8]};
endmodule : cia_add_ref
`default_nettype wire

// [sim/core_instr_timing_and_add_ops_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module core_instr_timing_and_add_ops_tb;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, refCin;
    logic [7:0] refA, refB, refRes;
    logic [3:0] refFl;
    logic [17:0] sel [3] = '{18'h2_2B20, 18'h3_2A20, 18'h1_2A0A};
    int err_total = 0, comparisons = 0;
    always #20 clk = ~clk;
    cia_core u_cia_core (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    cia_add_ref u_cia_add_ref (.a(refA), .b(refB), .cin(refCin), .res(refRes), .flags(refFl));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // one apb transfer held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin err_total++; give_verdict(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // load opcode, start it and poll status until idle
    task automatic go(input logic [15:0] op, input logic [31:0] ctl);
        int n;
        n = 0;
        xfer(1'b1, 12'h004, {16'h0, op});
        xfer(1'b1, 12'h000, ctl | 32'h0000_0001);
        do begin
            xfer(1'b0, 12'h010, 32'h0);
            n++;
        end while (rd[4] !== 1'b0 && n < 20);
        if (n >= 20) begin err_total++; give_verdict(); end
    endtask : go
    // one add with accumulator w, file f and carry c
    task automatic add_case(input logic [15:0] op, input logic [7:0] w, input logic [7:0] f,
        input logic c);
        logic toFile;
        toFile = op[8] && op[15:8] != 8'hB1;
        refA = w;
        refB = (op[15:8] == 8'hB1) ? op[7:0] : f;
        refCin = c & (op[15:9] == 7'h08);
        xfer(1'b1, 12'h00C, {24'h0, w});
        xfer(1'b1, 12'h008, {24'h0, f});
        xfer(1'b1, 12'h010, {31'h0, c});
        go(op, 32'h0);
        `CHK("flags", refFl, rd[3:0])
        xfer(1'b0, 12'h00C, 32'h0);
        `CHK("accumulator", toFile ? w : refRes, rd[7:0])
        xfer(1'b0, 12'h008, 32'h0);
        `CHK("file", toFile ? refRes : f, rd[7:0])
    endtask : add_case
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        xfer(1'b0, 12'h00C, 32'h0);
        `CHK("reset accumulator", 32'h0, rd)
        add_case(16'hB115, 8'h10, 8'h33, 1'b1);
        add_case(16'h0E20, 8'h17, 8'hC2, 1'b1);
        add_case(16'h0F20, 8'h80, 8'h80, 1'b0);
        add_case(16'h1020, 8'h4D, 8'h02, 1'b1);
        add_case(16'h1120, 8'hFF, 8'h00, 1'b1);
        $display("add tests done");
        // store-select: file only, both, accumulator address alone
        foreach (sel[i]) begin
            go(sel[i][15:0], 32'h0);
            `CHK("write targets", sel[i][17:16], rd[6:5])
        end
        go(16'hB734, 32'h0000_1200);
        xfer(1'b0, 12'h014, 32'h0);
        `CHK("program counter", 32'h0000_1234, rd)
        go(16'h3320, 32'h0000_0004);
        `CHK("skip idle", 1'b1, rd[7])
        go(16'h3320, 32'h0);
        `CHK("no skip", 1'b0, rd[7])
        $display("control tests done");
        // internal table write runs until the event bit
        xfer(1'b1, 12'h004, 32'h0000_AC20);
        xfer(1'b1, 12'h000, 32'h0000_0009);
        repeat (2) xfer(1'b0, 12'h010, 32'h0);
        `CHK("programming busy", 1'b1, rd[4])
        xfer(1'b1, 12'h000, 32'h0000_0010);
        xfer(1'b0, 12'h010, 32'h0);
        `CHK("ended by event", 1'b0, rd[4])
        go(16'hAC20, 32'h0);
        `CHK("external write", 1'b0, rd[4])
        xfer(1'b0, 12'h01C, 32'h0);
        `CHK("unmapped", 1'b1, er)
        $display("table and decode tests done");
        give_verdict();
    end
endmodule : core_instr_timing_and_add_ops_tb
`default_nettype wire
